// >>> rtl/epc_programmer.sv
// epc_programmer.sv: host controller that reads and fast-programs an 8k x 8 uv eprom
// assumes the eprom pins are wired straight to these ports and supplies follow vpp_high/vcc_high
//
// How it works
// (RULE1) the part holds 8192 bytes, 13-bit address, eight data pins
// (RULE2) data is driven only with both enables low and strobe high
// (RULE3) chip enable selects the part, output enable gates its data
// (RULE4) output enable high floats the part's data pins
// (RULE5) chip enable high is standby with data floating
// (RULE6) erased locations read as all ones
// (RULE7) programming only turns ones into zeros
// (RULE8) 21 V and chip enable low, address and data stable, then strobe low
// (RULE9) every location needing it gets pulses, any address order
// (RULE10) prime pulses last one millisecond
// (RULE11) read back after each prime pulse, final pulse on match
// (RULE12) no more than fifteen prime pulses per byte
// (RULE13) final pulse lasts four milliseconds per prime pulse used
// (RULE14) pulse and read-back loop runs at 6 V main and 21 V program
// (RULE15) final verify pass runs with both supplies at 5 V
// (RULE16) parallel parts share lines and run the same sequence
// (RULE17) chip enable or strobe high makes a part ignore pulses
// (RULE18) output enable stays high through a program pulse
// (RULE19) verify mode reads the stored byte with program supply on
// (RULE20) a byte failing after fifteen primes stops with a fail flag
`timescale 1ns/100ps
`default_nettype none
`include "epc_map.svh"
module epc_programmer
  import epc_pkg::*;
(
  // clock and reset
  input  wire logic      sys_clk,
  input  wire logic      sys_rst,
  // command port
  input  wire logic      cmd_valid,
  input  wire epc_cmd_t  cmd_op,
  input  wire epc_word_t cmd_word,
  output logic           cmd_ready,
  output logic           rsp_valid,
  output logic [7:0]     rsp_data,
  output logic           rsp_fail,
  output logic [3:0]     rsp_primes,
  // eprom pins
  output logic [12:0]    word_address,
  output logic [7:0]     data_pins_out,
  output logic           data_pins_oe,
  input  wire logic [7:0] data_pins_in,
  output epc_ctl_t       pins_ctl
);
  localparam int unsigned CNT_W = 21; // a 15-prime final pulse is 1.2M cycles, 18 bits would wrap

  epc_state_t      state, next_state;
  epc_cmd_t        op, next_op;
  epc_word_t       word, next_word;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic [3:0]      primes, next_primes;
  logic            final_ph, next_final_ph;
  logic            cmd_ready_r, next_cmd_ready;
  logic            rsp_valid_r, next_rsp_valid;
  logic [7:0]      rsp_data_r, next_rsp_data;
  logic            rsp_fail_r, next_rsp_fail;
  epc_ctl_t        ctl, next_ctl;
  logic            oe_r, next_oe;

  // sequencer: reads, prime/final pulse loop and plain verify
  always_comb begin
    next_state     = state;
    next_op        = op;
    next_word      = word;
    next_cnt       = cnt;
    next_primes    = primes;
    next_final_ph  = final_ph;
    next_cmd_ready = 1'b0;
    next_rsp_valid = 1'b0;
    next_rsp_data  = rsp_data_r;
    next_rsp_fail  = rsp_fail_r;
    next_ctl       = ctl;
    next_oe        = oe_r;
    unique case (state)
      EPC_IDLE: begin
        // standby: chip disabled, outputs floated, strobe idle high
        next_ctl  = '{ce_n: 1'b1, oe_n: 1'b1, write_strobe_n: 1'b1, vpp_high: 1'b0, vcc_high: 1'b0}; // RULE5 RULE17
        next_oe   = 1'b0;
        next_cmd_ready = 1'b1;
        if (cmd_valid && cmd_ready_r) begin
          next_cmd_ready = 1'b0;
          next_op        = cmd_op;
          next_word      = cmd_word;                                     // RULE1 RULE9
          next_primes    = 4'h0;
          next_final_ph  = 1'b0;
          next_cnt       = CNT_W'(`EPC_SETUP_CYC);
          next_rsp_fail  = 1'b0;
          next_ctl.ce_n  = 1'b0;                                         // RULE3
          if (cmd_op == EPC_CMD_PROG) begin
            next_ctl.vpp_high = 1'b1;                                    // RULE8 RULE14
            next_ctl.vcc_high = 1'b1;                                    // RULE14
            next_oe           = 1'b1;                                    // RULE8
            next_state        = EPC_SETUP;
          end else begin
            // read at normal supplies; verify pass at 5 V on both
            next_ctl.oe_n = 1'b0;                                        // RULE2 RULE15
            next_cnt      = CNT_W'(`EPC_ACCESS_CYC);
            next_state    = EPC_SAMPLE;
          end
        end
      end
      EPC_SETUP: begin
        // address, data and supplies settle before the strobe drops
        if (cnt == '0) begin
          next_ctl.write_strobe_n = 1'b0;                                // RULE8
          next_ctl.oe_n           = 1'b1;                                // RULE18
          next_cnt   = final_ph ? CNT_W'(`EPC_PRIME_CYC * `EPC_FINAL_MULT * primes)
                                : CNT_W'(`EPC_PRIME_CYC);                // RULE10 RULE13
          next_state = EPC_PULSE;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      EPC_PULSE: begin
        if (cnt == CNT_W'(1)) begin
          next_ctl.write_strobe_n = 1'b1;
          next_cnt   = CNT_W'(`EPC_SETUP_CYC);
          next_state = EPC_HOLD;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      EPC_HOLD: begin
        // data hold, then release the bus and read back after a prime pulse, or finish after the final pulse
        if (cnt == '0) begin
          if (final_ph) begin
            next_rsp_valid = 1'b1;
            next_state     = EPC_DONE;
          end else begin
            next_oe       = 1'b0;
            next_ctl.oe_n = 1'b0;                                        // RULE19 RULE11
            next_primes   = primes + 4'h1;                               // RULE12
            next_cnt      = CNT_W'(`EPC_ACCESS_CYC);
            next_state    = EPC_SAMPLE;
          end
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      EPC_SAMPLE: begin
        if (cnt == '0) begin
          next_rsp_data = data_pins_in;
          next_ctl.oe_n = 1'b1;                                          // RULE4
          if (op != EPC_CMD_PROG) begin
            next_rsp_fail  = (op == EPC_CMD_VERIFY) && (data_pins_in != word.data); // RULE15
            next_rsp_valid = 1'b1;
            next_state     = EPC_DONE;
          end else if (data_pins_in == word.data) begin
            next_final_ph = 1'b1;                                        // RULE11 RULE13
            next_oe       = 1'b1;
            next_cnt      = CNT_W'(`EPC_SETUP_CYC);
            next_state    = EPC_SETUP;
          end else if (primes == `EPC_MAX_PRIME) begin
            next_rsp_fail  = 1'b1;                                       // RULE20 RULE12
            next_rsp_valid = 1'b1;
            next_state     = EPC_DONE;
          end else begin
            next_oe    = 1'b1;                                           // RULE11
            next_cnt   = CNT_W'(`EPC_SETUP_CYC);
            next_state = EPC_SETUP;
          end
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      EPC_DONE: begin
        // one idle cycle so the response pulse stands alone
        next_ctl   = '{ce_n: 1'b1, oe_n: 1'b1, write_strobe_n: 1'b1, vpp_high: 1'b0, vcc_high: 1'b0};
        next_oe    = 1'b0;
        next_state = EPC_IDLE;
      end
    endcase
  end

  // state registers; reset parks the part in standby
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state       <= EPC_IDLE;
      op          <= EPC_CMD_READ;
      word        <= '0;
      cnt         <= '0;
      primes      <= 4'h0;
      final_ph    <= 1'b0;
      cmd_ready_r <= 1'b0;
      rsp_valid_r <= 1'b0;
      rsp_data_r  <= `EPC_ERASED;                                        // RULE6
      rsp_fail_r  <= 1'b0;
      ctl         <= '{ce_n: 1'b1, oe_n: 1'b1, write_strobe_n: 1'b1, vpp_high: 1'b0, vcc_high: 1'b0};
      oe_r        <= 1'b0;
    end else begin
      state       <= next_state;
      op          <= next_op;
      word        <= next_word;
      cnt         <= next_cnt;
      primes      <= next_primes;
      final_ph    <= next_final_ph;
      cmd_ready_r <= next_cmd_ready;
      rsp_valid_r <= next_rsp_valid;
      rsp_data_r  <= next_rsp_data;
      rsp_fail_r  <= next_rsp_fail;
      ctl         <= next_ctl;
      oe_r        <= next_oe;
    end
  end

  // outputs straight from flops; same pins fan out to parallel parts
  assign cmd_ready     = cmd_ready_r;
  assign rsp_valid     = rsp_valid_r;
  assign rsp_data      = rsp_data_r;
  assign rsp_fail      = rsp_fail_r;
  assign rsp_primes    = primes;
  assign word_address  = word.word_address;                              // RULE16
  assign data_pins_out = word.data;                                      // RULE7
  assign data_pins_oe  = oe_r;
  assign pins_ctl      = ctl;
endmodule : epc_programmer
`default_nettype wire

// >>> rtl/epc_map.svh
// epc_map.svh: address map, pin levels and timing counts for the eprom programmer
// assumes a 20 MHz sys_clk and an 8k x 8 uv eprom on the far side of the pins
`ifndef EPC_MAP_SVH
`define EPC_MAP_SVH
`define EPC_CLK_HZ        20000000
`define EPC_PRIME_US      1000
`define EPC_PRIME_CYC     ((`EPC_PRIME_US * (`EPC_CLK_HZ / 1000000)))
`define EPC_SETUP_US      2
`define EPC_SETUP_CYC     ((`EPC_SETUP_US * (`EPC_CLK_HZ / 1000000)))
`define EPC_ACCESS_CYC    10
`define EPC_MAX_PRIME     4'hF
`define EPC_FINAL_MULT    4
`define EPC_ERASED        8'hFF
`endif

// >>> rtl/epc_pkg.sv
// epc_pkg.sv: types shared by the eprom programmer
// assumes epc_map.svh supplies the numeric constants
package epc_pkg;
  typedef struct packed {
    logic [12:0] word_address;
    logic [7:0]  data;
  } epc_word_t;
  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic write_strobe_n;
    logic vpp_high;
    logic vcc_high;
  } epc_ctl_t;
  typedef enum logic [1:0] {EPC_CMD_READ, EPC_CMD_PROG, EPC_CMD_VERIFY} epc_cmd_t;
  typedef enum {EPC_IDLE, EPC_SETUP, EPC_PULSE, EPC_HOLD, EPC_SAMPLE, EPC_DONE} epc_state_t;
endpackage : epc_pkg

// >>> testbench/epc_programmer_assertions.sv
// epc_programmer_assertions.sv: pin checker for the eprom programmer
// assumes it is bound onto the epc_programmer ports
`timescale 1ns/100ps
`default_nettype none
module epc_programmer_chk
  import epc_pkg::*;
(
  // clock, reset and command port
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  input wire logic        cmd_valid,
  input wire epc_cmd_t    cmd_op,
  input wire logic        cmd_ready,
  input wire logic        rsp_valid,
  input wire logic        rsp_fail,
  input wire logic [3:0]  rsp_primes,
  // eprom pins
  input wire logic [12:0] word_address,
  input wire logic        data_pins_oe,
  input wire epc_ctl_t    pins_ctl
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  logic [20:0] low_cnt;
  logic [4:0]  primes;
  logic        take;
  logic        strb;
  assign take = cmd_valid && cmd_ready;
  assign strb = pins_ctl.write_strobe_n;
  // strobe low length, cleared while strobe is high, and prime tally, cleared per command
  always_ff @(posedge sys_clk) begin
    low_cnt <= strb ? 21'h0 : low_cnt + 21'h1;
    if (sys_rst || take) primes <= 5'h0;
    else if (strb && low_cnt == 21'h4E20) primes <= primes + 5'h1;
  end
  chk_strobe_gate: assert property (!strb |-> !pins_ctl.ce_n && pins_ctl.vpp_high && data_pins_oe)
    else $error("strobe low without select, supply or data");
  chk_pulse_quiet: assert property (!strb |-> pins_ctl.oe_n) else $error("output enable low in a pulse");
  chk_loop_supply: assert property (!strb |-> pins_ctl.vcc_high) else $error("pulse without raised supply");
  chk_pulse_len: assert property ($rose(strb) |-> low_cnt == 21'h4E20 ||
    (primes != 5'h0 && low_cnt == 21'h13880 * primes)) else $error("pulse length wrong");
  chk_prime_cap: assert property (primes <= 5'hF) else $error("too many prime pulses");
  chk_setup_held: assert property ($fell(strb) |-> $past(word_address, 39) == word_address &&
    $past(pins_ctl.ce_n, 39) == 1'b0) else $error("address or select not set up");
  chk_read_pins: assert property (take && cmd_op != EPC_CMD_PROG |=> (!pins_ctl.ce_n && !pins_ctl.oe_n &&
    strb && !pins_ctl.vpp_high && !pins_ctl.vcc_high) [*8]) else $error("read pins wrong");
  chk_read_answer: assert property (take && cmd_op != EPC_CMD_PROG |-> ##12 rsp_valid ##2 cmd_ready)
    else $error("read answer late");
  chk_primes_rsp: assert property (rsp_valid && primes != 5'h0 && !rsp_fail |-> rsp_primes == primes[3:0])
    else $error("prime count wrong");
endmodule : epc_programmer_chk
bind epc_programmer epc_programmer_chk u_chk (
  .sys_clk      (sys_clk),
  .sys_rst      (sys_rst),
  .cmd_valid    (cmd_valid),
  .cmd_op       (cmd_op),
  .cmd_ready    (cmd_ready),
  .rsp_valid    (rsp_valid),
  .rsp_fail     (rsp_fail),
  .rsp_primes   (rsp_primes),
  .word_address (word_address),
  .data_pins_oe (data_pins_oe),
  .pins_ctl     (pins_ctl)
);
`default_nettype wire

// >>> testbench/epc_eprom_model.sv
// epc_eprom_model.sv: behavioural 8k x 8 uv eprom
// assumes the bench feeds host pin values and takes the resolved bus
`timescale 1ns/100ps
`default_nettype none
module epc_eprom_model
  import epc_pkg::*;
(
  // host side pins
  input wire epc_ctl_t    ctl,
  input wire logic [12:0] addr,
  input wire logic [7:0]  host_data,
  input wire logic        host_oe,
  // resolved data bus
  output logic [7:0]      bus
);
  logic [7:0] mem [8192];
  logic       drive;
  // erased array reads all ones
  initial foreach (mem[i]) mem[i] = 8'hFF;
  // a pulse only clears bits, and only when selected with program supply
  always @(posedge ctl.write_strobe_n)
    if (!ctl.ce_n && ctl.vpp_high) mem[addr] = mem[addr] & host_data;
  assign drive = !ctl.ce_n && !ctl.oe_n && ctl.write_strobe_n;
  // floating bus shows the inverse byte so a stray sample never matches
  assign bus = host_oe ? host_data : drive ? mem[addr] : ~mem[addr];
endmodule : epc_eprom_model
`default_nettype wire

// >>> testbench/epc_programmer_tb.sv
// epc_programmer_tb.sv: self-checking bench for the eprom programmer
// assumes the eprom model on the pins; one program run is about 5 ms
`timescale 1ns/100ps
`default_nettype none
module epc_programmer_tb;
  import epc_pkg::*;
  typedef struct packed {epc_cmd_t op; epc_word_t w; logic [7:0] ed; logic ef;} epc_row_t;
  logic sys_clk, sys_rst, cmd_valid, cmd_ready, rsp_valid, rsp_fail, data_pins_oe;
  epc_cmd_t cmd_op;
  epc_word_t cmd_word;
  logic [7:0] rsp_data, data_pins_out, data_pins_in;
  logic [3:0] rsp_primes;
  logic [12:0] word_address;
  epc_ctl_t pins_ctl;
  int n_errors = 0;
  int n_tests = 0;
  epc_row_t rows [4] = '{'{EPC_CMD_READ, '{13'h0000, 8'h00}, 8'hFF, 1'b0},
    '{EPC_CMD_READ, '{13'h1FFF, 8'h00}, 8'hFF, 1'b0}, '{EPC_CMD_VERIFY, '{13'h0AAA, 8'hFF}, 8'hFF, 1'b0},
    '{EPC_CMD_VERIFY, '{13'h0555, 8'h7E}, 8'hFF, 1'b1}};
  epc_programmer DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_word(cmd_word), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_fail(rsp_fail), .rsp_primes(rsp_primes), .word_address(word_address),
    .data_pins_out(data_pins_out), .data_pins_oe(data_pins_oe), .data_pins_in(data_pins_in), .pins_ctl(pins_ctl));
  epc_eprom_model u_rom (.ctl(pins_ctl), .addr(word_address), .host_data(data_pins_out),
    .host_oe(data_pins_oe), .bus(data_pins_in));
  // 20 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic check(input string nm, input logic [7:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic end_of_test();
    $display("checks %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_of_test
  // one command at a falling edge, then wait for its bounded answer
  task automatic run(input epc_row_t r, input logic [3:0] ep);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1) @(negedge sys_clk);
    cmd_valid = 1'b1;
    cmd_op = r.op;
    cmd_word = r.w;
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 110000) begin
      @(negedge sys_clk);
      n++;
    end
    check("answer", rsp_valid, 1'b1);
    if (r.op != EPC_CMD_PROG) check("data", rsp_data, r.ed);
    if (r.op != EPC_CMD_READ) check("fail", rsp_fail, r.ef);
    if (r.op == EPC_CMD_PROG) check("primes", rsp_primes, ep);
  endtask : run
  // hang guard, sized above one full program run
  initial begin
    #5600000;
    n_errors++;
    end_of_test();
  end
  initial begin
    sys_rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_op = EPC_CMD_READ;
    cmd_word = '0;
    repeat (3) @(negedge sys_clk);
    check("reset ctl", pins_ctl, 5'h1C);
    check("reset oe", data_pins_oe, 1'b0);
    sys_rst = 1'b0;
    foreach (rows[i]) run(rows[i], 4'h0);
    run('{EPC_CMD_PROG, '{13'h1FFF, 8'h5A}, 8'h00, 1'b0}, 4'h1);
    run('{EPC_CMD_READ, '{13'h1FFF, 8'h00}, 8'h5A, 1'b0}, 4'h0);
    run('{EPC_CMD_READ, '{13'h1FFE, 8'h00}, 8'hFF, 1'b0}, 4'h0);
    run('{EPC_CMD_VERIFY, '{13'h1FFF, 8'h5A}, 8'h5A, 1'b0}, 4'h0);
    // reset in mid read must drop the part to standby; wait until the read is really taken
    while (cmd_ready !== 1'b1) @(negedge sys_clk);
    cmd_valid = 1'b1;
    cmd_op = EPC_CMD_READ;
    cmd_word = '{13'h1FFF, 8'h00};
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    repeat (3) @(negedge sys_clk);
    check("read ctl", pins_ctl, 5'h04);
    sys_rst = 1'b1;
    @(negedge sys_clk);
    check("abort ctl", pins_ctl, 5'h1C);
    check("abort ready", cmd_ready, 1'b0);
    check("abort data", rsp_data, 8'hFF);
    check("abort oe", data_pins_oe, 1'b0);
    sys_rst = 1'b0;
    run('{EPC_CMD_READ, '{13'h1FFF, 8'h00}, 8'h5A, 1'b0}, 4'h0);
    end_of_test();
  end
endmodule : epc_programmer_tb
`default_nettype wire
